// ==== verilog/lock_detect_pkg.sv ====
// Constants, types and helpers for the lock detector and its pad control
// Summary of operation
// - Lock after coded count of consecutive in-window comparisons
// - Enable bit gates all detection, resets to one
// - Window type bit picks digital timer or one-shot
// - Digital window length coded in half lock-timer cycles
// - Pad enable zero disables the shared pin
// - Pad enable and pad mode keep pin driven
// - Otherwise release pin on foreign chip address
// - Either edge may lead; only difference matters
// - Lock flag always readable in status register
// - Pin carries serial data during register reads
package lock_detect_pkg;
    localparam logic [7:0] REG_LD_CFG = 8'h07;
    localparam logic [7:0] REG_AEN_CFG = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h12;
    localparam logic [23:0] LD_CFG_RESET = 24'h00014D;
    localparam logic [23:0] AEN_CFG_RESET = 24'hC1BEFF;
    localparam int CNT_CODE_LSB = 0;
    localparam int LD_ENABLE_BIT = 3;
    localparam int WIN_TYPE_BIT = 6;
    localparam int WIN_CODE_LSB = 7;
    localparam int PAD_EN_BIT = 5;
    localparam int HF_REF_BIT = 21;
    localparam int STATUS_LOCK_BIT = 1;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ANALOG_WIN_NS = 10;
    // One-shot window rounds down, never below one cycle
    localparam int ANALOG_WIN_CYC_I = (ANALOG_WIN_NS / CLK_PERIOD_NS) < 1 ? 1
                                      : (ANALOG_WIN_NS / CLK_PERIOD_NS);
    localparam logic [7:0] ANALOG_WIN_CYC = 8'(ANALOG_WIN_CYC_I);

    typedef struct packed {
        logic enable;
        logic win_digital;
        logic [2:0] win_code;
        logic [2:0] cnt_code;
    } ld_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pad_t;

    function automatic logic [16:0] wincnt_target(input logic [2:0] code);
        case (code)
            3'h0: wincnt_target = 17'h00005;
            3'h1: wincnt_target = 17'h00020;
            3'h2: wincnt_target = 17'h00060;
            3'h3: wincnt_target = 17'h00100;
            3'h4: wincnt_target = 17'h00200;
            3'h5: wincnt_target = 17'h00800;
            3'h6: wincnt_target = 17'h02000;
            default: wincnt_target = 17'h0FFFF;
        endcase
    endfunction : wincnt_target

    // Window in half lock-timer cycles: code 0 is one half, code n is 2^n halves
    function automatic logic [7:0] win_halves(input logic [2:0] code);
        win_halves = (code == 3'h0) ? 8'h01 : 8'(8'h01 << code);
    endfunction : win_halves

    function automatic ld_cfg_t decode_cfg(input logic [23:0] r);
        ld_cfg_t c;
        c.enable = r[LD_ENABLE_BIT];
        c.win_digital = r[WIN_TYPE_BIT];
        c.win_code = r[WIN_CODE_LSB +: 3];
        c.cnt_code = r[CNT_CODE_LSB +: 3];
        return c;
    endfunction : decode_cfg
endpackage : lock_detect_pkg

// ==== verilog/arrival_compare.sv ====
// Measures the arrival gap between reference and divided edges
`timescale 1ns/100ps
module arrival_compare
    import lock_detect_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Edges and window
    input wire logic run,
    input wire logic ref_edge,
    input wire logic div_edge,
    input wire logic tick_en,
    input wire logic [7:0] limit,
    // Result
    output logic done_q,
    output logic in_win_q
);
    typedef enum logic {IDLE, WAIT} cmp_state_t;
    cmp_state_t state_q, state_d;
    logic ref_first_q, ref_first_d;
    logic [7:0] gap_q, gap_d;
    logic done_d, in_win_d;
    logic partner;

    always_comb begin
        state_d = state_q;
        ref_first_d = ref_first_q;
        gap_d = gap_q;
        done_d = 1'b0;
        in_win_d = in_win_q;
        partner = ref_first_q ? div_edge : ref_edge;
        case (state_q)
            IDLE: begin
                if (ref_edge && div_edge) begin
                    done_d = 1'b1;
                    in_win_d = 1'b1;
                end else if (ref_edge || div_edge) begin
                    // Whichever edge leads opens the window
                    state_d = WAIT;
                    ref_first_d = ref_edge;
                    // The entry tick counts, so a gap equal to the window is out
                    gap_d = tick_en ? 8'h01 : 8'h00;
                end
            end
            WAIT: begin
                if (partner) begin
                    done_d = 1'b1;
                    in_win_d = gap_q < limit;
                    state_d = IDLE;
                end else if (gap_q >= limit) begin
                    // Partner missed the window; a late partner reopens later
                    done_d = 1'b1;
                    in_win_d = 1'b0;
                    state_d = IDLE;
                end else if (tick_en) begin
                    gap_d = gap_q + 8'h01;
                end
            end
            default: state_d = IDLE;
        endcase
        if (!run) begin
            state_d = IDLE;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= IDLE;
            ref_first_q <= 1'b0;
            gap_q <= 8'h00;
            done_q <= 1'b0;
            in_win_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ref_first_q <= ref_first_d;
            gap_q <= gap_d;
            done_q <= done_d;
            in_win_q <= in_win_d;
        end
    end

    no_result_idle_a: assert property (@(posedge clk) disable iff (reset)
        !run |=> !done_q) else $error("comparison reported while stopped");
    late_edge_out_a: assert property (@(posedge clk) disable iff (reset)
        (run && state_q == WAIT && !partner && gap_q >= limit) |=> done_q && !in_win_q)
        else $error("late partner not reported out of window");
endmodule : arrival_compare

// ==== verilog/pll_lock_detect_control.sv ====
// Lock detector, its configuration registers and shared pad control
`timescale 1ns/100ps
module pll_lock_detect_control
    import lock_detect_pkg::*;
#(
    parameter int LD_CLK_DIV = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Phase detector edges, from outside the clock domain
    input wire logic ref_pin,
    input wire logic div_pin,
    // Register port from the serial interface
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Serial transaction state and pad mode
    input wire logic read_active,
    input wire logic sdo_bit,
    input wire logic xfer_active,
    input wire logic addr_mismatch,
    input wire logic pad_always_on,
    // Status and pad
    output logic lock_indicator_q,
    output logic hf_ref_q,
    output logic lock_or_serial_out_pin_q,
    output logic lock_or_serial_out_pin_oe_q
);
    if (LD_CLK_DIV < 2 || LD_CLK_DIV % 2 != 0 || LD_CLK_DIV > 256) begin : g_bad_div
        $error("LD_CLK_DIV must be even and within 2..256");
    end
    localparam int HALF_DIV = LD_CLK_DIV / 2;
    localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

    // Edge inputs: two synchroniser stages, then a third for edge finding
    logic [2:0] ref_sync_q, div_sync_q;
    logic ref_edge, div_edge;
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_sync_q <= 3'h0;
            div_sync_q <= 3'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[1:0], ref_pin};
            div_sync_q <= {div_sync_q[1:0], div_pin};
        end
    end
    assign ref_edge = ref_sync_q[1] && !ref_sync_q[2];
    assign div_edge = div_sync_q[1] && !div_sync_q[2];

    // Configuration registers
    logic [23:0] ld_cfg_q, ld_cfg_d, aen_cfg_q, aen_cfg_d;
    logic [23:0] rdata_d;
    logic rvalid_d;
    ld_cfg_t cfg;
    always_comb begin
        ld_cfg_d = ld_cfg_q;
        aen_cfg_d = aen_cfg_q;
        // Every bit is stored, reserved ones included; only decoded fields act
        if (reg_wr_en && reg_addr == REG_LD_CFG) begin
            ld_cfg_d = reg_wdata;
        end
        if (reg_wr_en && reg_addr == REG_AEN_CFG) begin
            aen_cfg_d = reg_wdata;
        end
        rvalid_d = reg_rd_en;
        rdata_d = 24'h000000;
        if (reg_rd_en) begin
            case (reg_addr)
                REG_LD_CFG: rdata_d = ld_cfg_q;
                REG_AEN_CFG: rdata_d = aen_cfg_q;
                // Lock flag readable at any time
                REG_STATUS: rdata_d[STATUS_LOCK_BIT] = lock_indicator_q;
                default: rdata_d = 24'h000000;
            endcase
        end
    end
    assign cfg = decode_cfg(ld_cfg_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            ld_cfg_q <= LD_CFG_RESET;
            aen_cfg_q <= AEN_CFG_RESET;
            reg_rdata_q <= 24'h000000;
            reg_rvalid_q <= 1'b0;
            hf_ref_q <= AEN_CFG_RESET[HF_REF_BIT];
        end else begin
            ld_cfg_q <= ld_cfg_d;
            aen_cfg_q <= aen_cfg_d;
            reg_rdata_q <= rdata_d;
            reg_rvalid_q <= rvalid_d;
            // Host keeps this set for references above 200 MHz
            hf_ref_q <= aen_cfg_d[HF_REF_BIT];
        end
    end

    // Lock-timer clock as a half-period enable from a divider
    logic [7:0] div_cnt_q, div_cnt_d;
    logic half_tick;
    always_comb begin
        half_tick = div_cnt_q == HALF_LAST;
        div_cnt_d = half_tick ? 8'h00 : div_cnt_q + 8'h01;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // Window source: digital timer in half lock-timer cycles, or fixed one-shot
    logic tick_en;
    logic [7:0] win_limit;
    always_comb begin
        if (cfg.win_digital) begin
            tick_en = half_tick;
            win_limit = win_halves(cfg.win_code);
        end else begin
            tick_en = 1'b1;
            win_limit = ANALOG_WIN_CYC;
        end
    end

    logic cmp_done, cmp_in;
    arrival_compare u_compare (
        .clk(clk),
        .reset(reset),
        .run(cfg.enable),
        .ref_edge(ref_edge),
        .div_edge(div_edge),
        .tick_en(tick_en),
        .limit(win_limit),
        .done_q(cmp_done),
        .in_win_q(cmp_in)
    );

    // Consecutive in-window count and lock flag
    logic [16:0] run_cnt_q, run_cnt_d, target;
    logic lock_d;
    always_comb begin
        target = wincnt_target(cfg.cnt_code);
        run_cnt_d = run_cnt_q;
        lock_d = lock_indicator_q;
        if (!cfg.enable) begin
            run_cnt_d = 17'h00000;
            lock_d = 1'b0;
        end else if (cmp_done && cmp_in) begin
            if (run_cnt_q < target) begin
                run_cnt_d = run_cnt_q + 17'h00001;
            end
            if (run_cnt_q + 17'h00001 >= target) begin
                lock_d = 1'b1;
            end
        end else if (cmp_done) begin
            run_cnt_d = 17'h00000;
            lock_d = 1'b0;
        end
    end

    // Shared pad: serial data during reads, otherwise lock flag
    pad_t pad_d;
    always_comb begin
        pad_d.out = read_active ? sdo_bit : lock_d;
        if (!aen_cfg_q[PAD_EN_BIT]) begin
            pad_d.oe = 1'b0;
        end else if (pad_always_on) begin
            pad_d.oe = 1'b1;
        end else begin
            // Releasing on a foreign address lets parts share one serial bus
            pad_d.oe = !(xfer_active && addr_mismatch);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            run_cnt_q <= 17'h00000;
            lock_indicator_q <= 1'b0;
            lock_or_serial_out_pin_q <= 1'b0;
            lock_or_serial_out_pin_oe_q <= 1'b0;
        end else begin
            run_cnt_q <= run_cnt_d;
            lock_indicator_q <= lock_d;
            lock_or_serial_out_pin_q <= pad_d.out;
            lock_or_serial_out_pin_oe_q <= pad_d.oe;
        end
    end

    lock_needs_count_a: assert property (@(posedge clk) disable iff (reset)
        $rose(lock_indicator_q) |-> $past(run_cnt_q) + 17'h00001 >= $past(target))
        else $error("lock declared before enough comparisons");
    disabled_no_lock_a: assert property (@(posedge clk) disable iff (reset)
        !cfg.enable |=> !lock_indicator_q && run_cnt_q == 17'h00000)
        else $error("lock present while detection disabled");
    miss_clears_lock_a: assert property (@(posedge clk) disable iff (reset)
        (cfg.enable && cmp_done && !cmp_in) |=> !lock_indicator_q && run_cnt_q == 17'h00000)
        else $error("out-of-window comparison kept lock");
    digital_limit_a: assert property (@(posedge clk) disable iff (reset)
        cfg.win_digital && cfg.win_code == 3'h7 |-> win_limit == 8'h80)
        else $error("digital window length wrong");
    analog_window_a: assert property (@(posedge clk) disable iff (reset)
        !cfg.win_digital |-> win_limit == ANALOG_WIN_CYC && tick_en)
        else $error("one-shot window not selected");
    pad_disabled_a: assert property (@(posedge clk) disable iff (reset)
        !aen_cfg_q[PAD_EN_BIT] |=> !lock_or_serial_out_pin_oe_q)
        else $error("pin driven while pad disabled");
    pad_always_on_a: assert property (@(posedge clk) disable iff (reset)
        aen_cfg_q[PAD_EN_BIT] && pad_always_on |=> lock_or_serial_out_pin_oe_q)
        else $error("pin released in always-on mode");
    pad_release_a: assert property (@(posedge clk) disable iff (reset)
        aen_cfg_q[PAD_EN_BIT] && !pad_always_on && xfer_active && addr_mismatch
        |=> !lock_or_serial_out_pin_oe_q)
        else $error("pin kept on foreign address");
    status_read_a: assert property (@(posedge clk) disable iff (reset)
        reg_rd_en && reg_addr == REG_STATUS
        |=> reg_rvalid_q && reg_rdata_q[STATUS_LOCK_BIT] == $past(lock_indicator_q))
        else $error("status read does not show lock flag");
    read_sdo_a: assert property (@(posedge clk) disable iff (reset)
        read_active |=> lock_or_serial_out_pin_q == $past(sdo_bit))
        else $error("pin not carrying serial data during read");
endmodule : pll_lock_detect_control

// ==== tb/host_model.sv ====
// Host controller model driving the register port of the lock detector
`timescale 1ns/100ps
module host_model
    import lock_detect_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'hFF;
        reg_wdata = 24'h000000;
    end

    // Idle bus shows the inverse of the last value, so a stale match cannot pass
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        repeat ($urandom % 3) @(posedge clk);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
        repeat ($urandom % 3) @(posedge clk);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rvalid_q;
        d = reg_rdata_q;
    endtask : rd

    task automatic config_ref(input int ref_mhz, input logic [23:0] base);
        logic [23:0] v;
        v = base;
        v[HF_REF_BIT] = ref_mhz > 200;
        wr(REG_AEN_CFG, v);
    endtask : config_ref
endmodule : host_model

// ==== tb/tb.sv ====
// Self-checking bench for the lock detector and pad control
`timescale 1ns/100ps
module tb
    import lock_detect_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ref_pin = 1'b0;
    logic div_pin = 1'b0;
    logic read_active = 1'b0;
    logic sdo_bit = 1'b0;
    logic xfer_active = 1'b0;
    logic addr_mismatch = 1'b0;
    logic pad_always_on = 1'b0;
    logic reg_wr_en, reg_rd_en, reg_rvalid_q, lock_q, hf_q, pin_q, oe_q;
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata_q;
    logic exp_lock = 1'b0;
    int fails = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;

    // Divider of 2 makes one tick per clock, keeping window sweeps short
    pll_lock_detect_control #(.LD_CLK_DIV(2)) DUT (.clk(clk), .reset(reset),
        .ref_pin(ref_pin), .div_pin(div_pin), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .read_active(read_active), .sdo_bit(sdo_bit),
        .xfer_active(xfer_active), .addr_mismatch(addr_mismatch),
        .pad_always_on(pad_always_on), .lock_indicator_q(lock_q), .hf_ref_q(hf_q),
        .lock_or_serial_out_pin_q(pin_q), .lock_or_serial_out_pin_oe_q(oe_q));

    host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q));

    function automatic int exp_target(input int code);
        int t[8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
        return t[code];
    endfunction : exp_target

    // One-shot spans two ticks; digital window is one tick at code 0
    function automatic int exp_limit(input logic dig, input int code);
        return !dig ? 2 : (code == 0 ? 1 : 1 << code);
    endfunction : exp_limit

    function automatic logic exp_oe(input logic en, on, x, m);
        return en && (on || !(x && m));
    endfunction : exp_oe

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word(24'(got), 24'(exp));
    endtask : chk_bit

    task automatic chk_rd(input logic [7:0] a, input logic [23:0] exp);
        logic [23:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk_bit(ok, 1'b1);
        chk_word(d, exp);
    endtask : chk_rd

    task automatic pair(input int gap, input int lim);
        logic lead;
        lead = 1'($urandom);
        @(posedge clk);
        ref_pin <= lead || gap == 0;
        div_pin <= !lead || gap == 0;
        if (gap > 0) begin
            repeat (gap) @(posedge clk);
            ref_pin <= 1'b1;
            div_pin <= 1'b1;
        end
        repeat (3) @(posedge clk);
        ref_pin <= 1'b0;
        div_pin <= 1'b0;
        // Idle long enough for a stray late edge to time out alone
        repeat (lim + 6) @(posedge clk);
        #1;
    endtask : pair

    task automatic run_cfg(input int cc, wc, input logic dig, en, miss);
        logic [23:0] cfg;
        int lim;
        int n;
        cfg = 24'($urandom) & 24'hFFFC30;
        cfg = cfg | 24'(cc) | 24'(en) << LD_ENABLE_BIT;
        cfg = cfg | 24'(dig) << WIN_TYPE_BIT | 24'(wc) << WIN_CODE_LSB;
        lim = exp_limit(dig, wc);
        n = exp_target(cc);
        host.wr(REG_LD_CFG, cfg);
        chk_rd(REG_LD_CFG, cfg);
        for (int i = 0; i < n; i++) begin
            pair(i == 0 ? lim - 1 : int'($urandom % lim), lim);
            if (i == n - 2) chk_bit(lock_q, 1'b0);
        end
        exp_lock = en;
        chk_bit(lock_q, exp_lock);
        chk_rd(REG_STATUS, 24'(exp_lock) << STATUS_LOCK_BIT);
        if (miss) begin
            pair(lim, lim);
            exp_lock = 1'b0;
            chk_bit(lock_q, 1'b0);
        end
        $display("test cfg %0d %0d %0d %0d done", cc, wc, dig, en);
    endtask : run_cfg

    task automatic pad_test;
        logic s;
        for (int k = 0; k < 16; k++) begin
            host.wr(REG_AEN_CFG,
                AEN_CFG_RESET & ~(24'h1 << PAD_EN_BIT) | 24'(k[0]) << PAD_EN_BIT);
            s = 1'($urandom);
            pad_always_on <= k[1];
            xfer_active <= k[2];
            addr_mismatch <= k[3];
            read_active <= 1'b1;
            sdo_bit <= s;
            repeat (2) @(posedge clk);
            #1;
            chk_bit(oe_q, exp_oe(k[0], k[1], k[2], k[3]));
            chk_bit(pin_q, s);
            @(posedge clk);
            read_active <= 1'b0;
            sdo_bit <= !exp_lock;
            repeat (2) @(posedge clk);
            #1;
            chk_bit(pin_q, exp_lock);
        end
        $display("test pad done");
    endtask : pad_test

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Roughly one and a half times the expected run, well under the cycle budget
    initial begin
        #400000;
        fails++;
        close_out;
    end

    initial begin
        void'($urandom(6));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk_bit(oe_q, 1'b1);
        chk_bit(hf_q, 1'b0);
        chk_rd(REG_LD_CFG, LD_CFG_RESET);
        chk_rd(REG_AEN_CFG, AEN_CFG_RESET);
        host.wr(REG_STATUS, 24'hFFFFFF);
        chk_rd(REG_STATUS, 24'h000000);
        chk_rd(8'h33, 24'h000000);
        $display("test reset done");
        for (int c = 0; c < 6; c++) run_cfg(c, 2, 1'b1, 1'b1, 1'b1);
        for (int w = 0; w < 8; w++) run_cfg(0, w, 1'b1, 1'b1, 1'b1);
        run_cfg(0, 7, 1'b0, 1'b1, 1'b1);
        run_cfg(0, 2, 1'b1, 1'b0, 1'b1);
        run_cfg(0, 3, 1'b1, 1'b1, 1'b0);
        pad_test;
        host.config_ref(250, AEN_CFG_RESET);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(hf_q, 1'b1);
        chk_rd(REG_AEN_CFG, AEN_CFG_RESET | 24'h1 << HF_REF_BIT);
        host.config_ref(100, AEN_CFG_RESET);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(hf_q, 1'b0);
        $display("test hf_ref done");
        close_out;
    end
endmodule : tb
